// ==== hdl/pkfc_pkg.sv ====
// pkfc_pkg: shared constants for the three-pin port function control block
// assumes a byte-addressed register port; every register occupies one aligned word
package pkfc_pkg;

  localparam int PKFC_PINS = 3;
  localparam int PKFC_AW = 8;
  localparam int PKFC_DW = 32;

  // register byte offsets
  localparam logic [7:0] PKFC_OFS_DATA = 8'h00;
  localparam logic [7:0] PKFC_OFS_OUTCTL = 8'h04;
  localparam logic [7:0] PKFC_OFS_FSEL1 = 8'h08;
  localparam logic [7:0] PKFC_OFS_FSEL2 = 8'h0c;
  localparam logic [7:0] PKFC_OFS_PULLUP = 8'h2c;
  localparam logic [7:0] PKFC_OFS_INEN = 8'h38;

  // writable-field masks within the low three bits
  localparam logic [2:0] PKFC_MASK_DATA = 3'h7;
  localparam logic [2:0] PKFC_MASK_OUTCTL = 3'h7;
  localparam logic [2:0] PKFC_MASK_FSEL1 = 3'h7;
  localparam logic [2:0] PKFC_MASK_FSEL2 = 3'h2;
  localparam logic [2:0] PKFC_MASK_PULLUP = 3'h6;
  localparam logic [2:0] PKFC_MASK_INEN = 3'h7;

  // field positions
  localparam int PKFC_BIT_PIN0 = 0;
  localparam int PKFC_BIT_PIN1 = 1;
  localparam int PKFC_BIT_PIN2 = 2;

  // reset values
  localparam logic [2:0] PKFC_RST_FIELD = 3'h0;
  localparam logic [31:0] PKFC_RST_RDATA = 32'h0000_0000;

endpackage

// ==== hdl/pkfc_sync.sv ====
// pkfc_sync: three-flop input synchroniser with agreement filter
// assumes the input is asynchronous to sys_clk; output changes once stages two and three agree
`timescale 1ns/10ps
module pkfc_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // raw and filtered level
  input wire logic async_in,
  output logic sync_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } pkfc_sync_t;

  pkfc_sync_t st;
  pkfc_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // s1 only feeds s2, so no metastable value reaches the compare
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.q;

endmodule // pkfc_sync

// ==== hdl/pkfc_pin_cell.sv ====
// pkfc_pin_cell: per-pin output multiplexer and pad control flops
// assumes control inputs come from registers on sys_clk; the pad output enable is active low, the input enable active high
`timescale 1ns/10ps
module pkfc_pin_cell #(
  parameter bit OPEN_DRAIN = 1'b0,
  parameter bit HAS_PULL = 1'b1,
  parameter bit PULL_RST = 1'b0,
  parameter bit BOOT_IN = 1'b0,
  parameter bit FUNC_GATED = 1'b0
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // port settings
  input wire logic port_data,
  input wire logic port_oe,
  input wire logic pull_req,
  input wire logic in_req,
  // peripheral function
  input wire logic func_sel,
  input wire logic func_data,
  input wire logic func_oe,
  // pad controls
  output logic pad_out,
  output logic pad_oe_n,
  output logic pad_pull,
  output logic pad_in_en
);

  typedef struct packed {
    logic out;
    logic oe_n;
    logic pull;
    logic in_en;
  } pkfc_cell_t;

  pkfc_cell_t st;
  pkfc_cell_t next_st;
  logic drive_val;
  logic drive_en;

  always_comb begin
    next_st = st;
    drive_val = func_sel ? func_data : port_data;
    drive_en = port_oe;
    if (func_sel && FUNC_GATED) begin
      drive_en = func_oe;
    end
    if (OPEN_DRAIN) begin
      // only ever sink: a high value releases the pad
      next_st.out = 1'b0;
      next_st.oe_n = !(drive_en && !drive_val);
    end else begin
      next_st.out = drive_val;
      next_st.oe_n = !drive_en;
    end
    next_st.pull = HAS_PULL && pull_req;
    next_st.in_en = in_req;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.out <= 1'b0;
      st.oe_n <= 1'b1;
      // reset-sensitive pulls sit at zero while reset is held
      st.pull <= PULL_RST;
      // boot pins keep the input path open through reset
      st.in_en <= BOOT_IN;
    end else begin
      st <= next_st;
    end
  end

  assign pad_out = st.out;
  assign pad_oe_n = st.oe_n;
  assign pad_pull = st.pull;
  assign pad_in_en = st.in_en;

endmodule // pkfc_pin_cell

// ==== hdl/pkfc_port.sv ====
// pkfc_port: three-pin port with function select, pull-up and input enable registers
// assumes a single-cycle register port master on sys_clk and peripheral signals on sys_clk
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/10ps
// Behaviour
// - pin2 select bit picks timer9 output
// - pin1 select-one bit picks system clock output when select-two bit1 is clear
// - pin0 select bit stored, never selects function
// - select-two bit1 puts alarm on pin1
// - pull-up writable on pins 2,1 only
// - input enable per pin zero to two
// - undefined register bits read as zero
// - reset-sensitive pulls forced off in reset
// - pulls with PULL_RST set held on in reset
// - boot pin input stays enabled in reset
// - gated pin types driven by function enable
// - pin0 is open drain, sinks only
// - reset leaves all pins plain, disabled
module pkfc_port
  import pkfc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // register port
  input wire logic [PKFC_AW-1:0] reg_addr,
  input wire logic [PKFC_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [PKFC_DW-1:0] reg_rdata,
  // peripheral functions
  input wire logic timer9_output,
  input wire logic system_clock_output,
  input wire logic alarm_n,
  // pads
  input wire logic [PKFC_PINS-1:0] pin_in,
  output logic [PKFC_PINS-1:0] pin_out,
  output logic [PKFC_PINS-1:0] pin_oe_n,
  output logic [PKFC_PINS-1:0] pin_pullup,
  output logic [PKFC_PINS-1:0] pin_in_en
);

  typedef struct packed {
    logic [2:0] port_data;
    logic [2:0] out_ctl;
    logic [2:0] function_select_one_reg;
    logic [2:0] function_select_two_reg;
    logic [2:0] pullup_enable_reg;
    logic [2:0] input_enable_reg;
    logic [PKFC_DW-1:0] rdata;
  } pkfc_state_t;

  pkfc_state_t st;
  pkfc_state_t next_st;
  logic [PKFC_PINS-1:0] pin_level;
  logic pin2_function_sel;
  logic pin1_function_sel_a;
  logic pin0_function_sel;
  logic pin1_function_sel_b;

  // merge the writable bits of a write into a stored field
  function automatic logic [2:0] pkfc_merge(input logic [2:0] old_val,
                                            input logic [2:0] wr_val,
                                            input logic [2:0] mask);
    pkfc_merge = (old_val & ~mask) | (wr_val & mask);
  endfunction

  // pad level where the input path is on, else the output latch when driving
  function automatic logic [2:0] pkfc_data_view(input logic [2:0] lvl,
                                                input logic [2:0] ie,
                                                input logic [2:0] latch,
                                                input logic [2:0] oe);
    pkfc_data_view = (lvl & ie) | (latch & oe & ~ie);
  endfunction

  always_comb begin
    next_st = st;
    next_st.rdata = PKFC_RST_RDATA;
    if (reg_wr) begin
      if (reg_addr == PKFC_OFS_DATA) begin
        next_st.port_data = pkfc_merge(st.port_data, reg_wdata[2:0], PKFC_MASK_DATA);
      end else if (reg_addr == PKFC_OFS_OUTCTL) begin
        next_st.out_ctl = pkfc_merge(st.out_ctl, reg_wdata[2:0], PKFC_MASK_OUTCTL);
      end else if (reg_addr == PKFC_OFS_FSEL1) begin
        next_st.function_select_one_reg = pkfc_merge(st.function_select_one_reg,
          reg_wdata[2:0], PKFC_MASK_FSEL1);
      end else if (reg_addr == PKFC_OFS_FSEL2) begin
        next_st.function_select_two_reg = pkfc_merge(st.function_select_two_reg,
          reg_wdata[2:0], PKFC_MASK_FSEL2);
      end else if (reg_addr == PKFC_OFS_PULLUP) begin
        next_st.pullup_enable_reg = pkfc_merge(st.pullup_enable_reg,
          reg_wdata[2:0], PKFC_MASK_PULLUP);
      end else if (reg_addr == PKFC_OFS_INEN) begin
        next_st.input_enable_reg = pkfc_merge(st.input_enable_reg,
          reg_wdata[2:0], PKFC_MASK_INEN);
      end
    end
    // unmapped reads and upper bits answer zero
    if (reg_rd) begin
      if (reg_addr == PKFC_OFS_DATA) begin
        next_st.rdata[2:0] = pkfc_data_view(pin_level, st.input_enable_reg,
          st.port_data, st.out_ctl);
      end else if (reg_addr == PKFC_OFS_OUTCTL) begin
        next_st.rdata[2:0] = st.out_ctl;
      end else if (reg_addr == PKFC_OFS_FSEL1) begin
        next_st.rdata[2:0] = st.function_select_one_reg;
      end else if (reg_addr == PKFC_OFS_FSEL2) begin
        next_st.rdata[2:0] = st.function_select_two_reg & PKFC_MASK_FSEL2;
      end else if (reg_addr == PKFC_OFS_PULLUP) begin
        next_st.rdata[2:0] = st.pullup_enable_reg & PKFC_MASK_PULLUP;
      end else if (reg_addr == PKFC_OFS_INEN) begin
        next_st.rdata[2:0] = st.input_enable_reg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st.port_data <= PKFC_RST_FIELD;
      st.out_ctl <= PKFC_RST_FIELD;
      st.function_select_one_reg <= PKFC_RST_FIELD;
      st.function_select_two_reg <= PKFC_RST_FIELD;
      st.pullup_enable_reg <= PKFC_RST_FIELD;
      st.input_enable_reg <= PKFC_RST_FIELD;
      st.rdata <= PKFC_RST_RDATA;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;

  assign pin2_function_sel = st.function_select_one_reg[PKFC_BIT_PIN2];
  assign pin1_function_sel_a = st.function_select_one_reg[PKFC_BIT_PIN1];
  assign pin1_function_sel_b = st.function_select_two_reg[PKFC_BIT_PIN1];
  // the pin0 select value is reserved, so it is kept but never used
  assign pin0_function_sel = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < PKFC_PINS; gi++) begin : g_sync
      pkfc_sync u_sync (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .async_in(pin_in[gi]),
        .sync_out(pin_level[gi])
      );
    end
  endgenerate

  // pin2: timer output, reset-sensitive pull-up
  pkfc_pin_cell #(.OPEN_DRAIN(1'b0), .HAS_PULL(1'b1)) u_pin2 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .port_data(st.port_data[PKFC_BIT_PIN2]),
    .port_oe(st.out_ctl[PKFC_BIT_PIN2]),
    .pull_req(st.pullup_enable_reg[PKFC_BIT_PIN2]),
    .in_req(st.input_enable_reg[PKFC_BIT_PIN2]),
    .func_sel(pin2_function_sel),
    .func_data(timer9_output),
    .func_oe(1'b0),
    .pad_out(pin_out[2]),
    .pad_oe_n(pin_oe_n[2]),
    .pad_pull(pin_pullup[2]),
    .pad_in_en(pin_in_en[2])
  );

  // pin1: alarm takes priority over the clock output when both are selected
  pkfc_pin_cell #(.OPEN_DRAIN(1'b0), .HAS_PULL(1'b1)) u_pin1 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .port_data(st.port_data[PKFC_BIT_PIN1]),
    .port_oe(st.out_ctl[PKFC_BIT_PIN1]),
    .pull_req(st.pullup_enable_reg[PKFC_BIT_PIN1]),
    .in_req(st.input_enable_reg[PKFC_BIT_PIN1]),
    .func_sel(pin1_function_sel_a | pin1_function_sel_b),
    .func_data(pin1_function_sel_b ? alarm_n : system_clock_output),
    .func_oe(1'b0),
    .pad_out(pin_out[1]),
    .pad_oe_n(pin_oe_n[1]),
    .pad_pull(pin_pullup[1]),
    .pad_in_en(pin_in_en[1])
  );

  // pin0: open drain, no pull-up
  pkfc_pin_cell #(.OPEN_DRAIN(1'b1), .HAS_PULL(1'b0)) u_pin0 (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .port_data(st.port_data[PKFC_BIT_PIN0]),
    .port_oe(st.out_ctl[PKFC_BIT_PIN0]),
    .pull_req(1'b0),
    .in_req(st.input_enable_reg[PKFC_BIT_PIN0]),
    .func_sel(pin0_function_sel),
    .func_data(1'b0),
    .func_oe(1'b0),
    .pad_out(pin_out[0]),
    .pad_oe_n(pin_oe_n[0]),
    .pad_pull(pin_pullup[0]),
    .pad_in_en(pin_in_en[0])
  );

  AST_TIMER_ON_PIN2: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(pin2_function_sel) |-> pin_out[2] == $past(timer9_output))
    else $error("pin2 does not follow timer output");

  AST_CLOCK_ON_PIN1: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(pin1_function_sel_a && !pin1_function_sel_b)
      |-> pin_out[1] == $past(system_clock_output))
    else $error("pin1 does not follow system clock output");

  AST_PIN0_STAYS_PORT: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(st.function_select_one_reg[0])
      |-> pin_oe_n[0] == !$past(st.out_ctl[0] && !st.port_data[0]))
    else $error("pin0 left port operation");

  AST_ALARM_ON_PIN1: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(pin1_function_sel_b) |-> pin_out[1] == $past(alarm_n))
    else $error("pin1 does not follow alarm");

  AST_PULLUP_BIT0_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd && reg_addr == PKFC_OFS_PULLUP) |-> reg_rdata[0] == 1'b0)
    else $error("pull-up bit0 read non-zero");

  AST_INEN_TAKES_EFFECT: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == PKFC_OFS_INEN |=> ##1 pin_in_en == $past(reg_wdata[2:0], 2))
    else $error("input enable not applied two edges after write");

  AST_UPPER_BITS_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_rdata[31:3] == 29'h0000_0000)
    else $error("undefined read bits non-zero");

  AST_PIN0_SINK_ONLY: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_out[0] == 1'b0 && pin_pullup[0] == 1'b0)
    else $error("pin0 drives high or pulls up");

  AST_FSEL1_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == PKFC_OFS_FSEL1
      |=> st.function_select_one_reg == $past(reg_wdata[2:0]))
    else $error("function select one not written");

  AST_FSEL1_HOLDS: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr != PKFC_OFS_FSEL1
      |=> st.function_select_one_reg == $past(st.function_select_one_reg))
    else $error("function select one changed by another write");

  AST_FSEL2_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == PKFC_OFS_FSEL2
      |=> st.function_select_two_reg == ($past(reg_wdata[2:0]) & PKFC_MASK_FSEL2))
    else $error("function select two holds more than its one bit");

  AST_PULLUP_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == PKFC_OFS_PULLUP
      |=> st.pullup_enable_reg == ($past(reg_wdata[2:0]) & PKFC_MASK_PULLUP))
    else $error("pull-up enable holds a bit without control");

  AST_INEN_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_wr && reg_addr == PKFC_OFS_INEN
      |=> st.input_enable_reg == $past(reg_wdata[2:0]))
    else $error("input enable not written");

  AST_PULLUP_PAD: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_pullup == {$past(st.pullup_enable_reg[2:1]), 1'b0})
    else $error("pad pull-up does not follow its enable");

  AST_INEN_PAD: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_in_en == $past(st.input_enable_reg))
    else $error("pad input path does not follow its enable");

  AST_OE_FOLLOWS_CTL: assert property (@(posedge sys_clk) disable iff (!nrst)
    pin_oe_n[2:1] == ~$past(st.out_ctl[2:1]))
    else $error("pad driver does not follow output control");

  AST_PORT_ON_PIN2: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(!pin2_function_sel) |-> pin_out[2] == $past(st.port_data[2]))
    else $error("pin2 does not follow port data");

  AST_PORT_ON_PIN1: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(!pin1_function_sel_a && !pin1_function_sel_b)
      |-> pin_out[1] == $past(st.port_data[1]))
    else $error("pin1 does not follow port data");

  AST_PIN0_RELEASE: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(st.port_data[0]) |-> pin_oe_n[0])
    else $error("pin0 driven while its data is one");

  AST_RDATA_IDLE: assert property (@(posedge sys_clk) disable iff (!nrst)
    !$past(reg_rd) |-> reg_rdata == PKFC_RST_RDATA)
    else $error("read data not zero outside a read");

  AST_FSEL1_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd && reg_addr == PKFC_OFS_FSEL1)
      |-> reg_rdata[2:0] == $past(st.function_select_one_reg))
    else $error("function select one read back wrong");

  AST_FSEL2_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd && reg_addr == PKFC_OFS_FSEL2)
      |-> reg_rdata[0] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("function select two undefined bits read non-zero");

  AST_OUTCTL_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd && reg_addr == PKFC_OFS_OUTCTL)
      |-> reg_rdata[2:0] == $past(st.out_ctl))
    else $error("output control read back wrong");

  AST_INEN_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
    $past(reg_rd && reg_addr == PKFC_OFS_INEN)
      |-> reg_rdata[2:0] == $past(st.input_enable_reg))
    else $error("input enable read back wrong");

endmodule // pkfc_port

// ==== testbench/pkfc_pin_model.sv ====
// pkfc_pin_model: board side of the three port pads, resolving each pad level
// assumes pad controls come straight from the port; ext_drive lets the bench drive a pad
`timescale 1ns/10ps
module pkfc_pin_model (
  // clock
  input wire logic sys_clk,
  // pad controls from the port
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  input wire logic [2:0] pin_pullup,
  // board drive
  input wire logic [2:0] ext_drive,
  input wire logic [2:0] ext_level,
  // resolved pad levels
  output logic [2:0] pin_in
);
  // an undriven pad keeps no level, so it wanders every cycle
  logic [2:0] float_lvl = 3'h2;

  always @(posedge sys_clk) begin
    float_lvl <= ~float_lvl;
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!pin_oe_n[i]) begin
        // pin zero only sinks, the others push their data
        pin_in[i] = (i == 0) ? 1'b0 : pin_out[i];
      end else if (ext_drive[i]) begin
        pin_in[i] = ext_level[i];
      end else if (pin_pullup[i]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_lvl[i];
      end
    end
  end
endmodule // pkfc_pin_model

// ==== testbench/test_port_k_function_control.sv ====
// test_port_k_function_control: bench comparing the port against a cycle model
// assumes register writes land one edge after the strobe and pads one edge after that
`timescale 1ns/10ps
module test_port_k_function_control
  import pkfc_pkg::*;
;
  logic sys_clk, nrst, reg_wr, reg_rd, rnd_on;
  logic timer9_output, system_clock_output, alarm_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_in_en, ext_drive, ext_level;
  int fail_count = 0;
  int checks_done = 0;
  logic [2:0] m_d = 3'h0, m_c = 3'h0, m_f1 = 3'h0, m_f2 = 3'h0, m_pu = 3'h0, m_ie = 3'h0;
  logic [2:0] e_out = 3'h0, e_oe_n = 3'h7, e_pu = 3'h0, e_ie = 3'h0;
  logic [2:0] m_lvl = 3'h0;
  logic [31:0] e_rd = 32'h0;
  logic [7:0] addrs[$] = '{PKFC_OFS_DATA, PKFC_OFS_OUTCTL, PKFC_OFS_FSEL1, PKFC_OFS_FSEL2,
                          PKFC_OFS_PULLUP, PKFC_OFS_INEN, 8'h10, 8'h3c};

  pkfc_port u_pkfc_port (.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer9_output(timer9_output), .system_clock_output(system_clock_output),
    .alarm_n(alarm_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup(pin_pullup), .pin_in_en(pin_in_en));

  pkfc_pin_model u_pkfc_pin_model (.sys_clk(sys_clk), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .ext_drive(ext_drive),
    .ext_level(ext_level), .pin_in(pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // enabled inputs return the settled pad level that the scenario in flight has set up
  function automatic logic [2:0] rd_val(input logic [7:0] a);
    case (a)
      PKFC_OFS_DATA: return (m_lvl & m_ie) | (~m_ie & m_c & m_d);
      PKFC_OFS_OUTCTL: return m_c;
      PKFC_OFS_FSEL1: return m_f1;
      PKFC_OFS_FSEL2: return m_f2;
      PKFC_OFS_PULLUP: return m_pu;
      PKFC_OFS_INEN: return m_ie;
      default: return 3'h0;
    endcase
  endfunction

  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      {m_d, m_c, m_f1, m_f2, m_pu, m_ie} = 18'h0;
      {e_out, e_pu, e_ie} = 9'h0;
      e_oe_n = 3'h7;
      e_rd = 32'h0;
    end else begin
      e_oe_n = {~m_c[2], ~m_c[1], ~(m_c[0] & ~m_d[0])};
      e_out[2] = m_f1[2] ? timer9_output : m_d[2];
      e_out[1] = m_f2[1] ? alarm_n : (m_f1[1] ? system_clock_output : m_d[1]);
      e_out[0] = 1'b0;
      e_pu = m_pu;
      e_ie = m_ie;
      e_rd = reg_rd ? {29'h0, rd_val(reg_addr)} : 32'h0;
      if (reg_wr) begin
        case (reg_addr)
          PKFC_OFS_DATA: m_d = reg_wdata[2:0];
          PKFC_OFS_OUTCTL: m_c = reg_wdata[2:0];
          PKFC_OFS_FSEL1: m_f1 = reg_wdata[2:0];
          PKFC_OFS_FSEL2: m_f2 = reg_wdata[2:0] & 3'h2;
          PKFC_OFS_PULLUP: m_pu = reg_wdata[2:0] & 3'h6;
          PKFC_OFS_INEN: m_ie = reg_wdata[2:0];
          default: ;
        endcase
      end
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // compared at the falling edge, half a cycle after the pads settle
  always @(negedge sys_clk) begin
    chk(reg_rdata, e_rd);
    chk({29'h0, pin_oe_n}, {29'h0, e_oe_n});
    chk({29'h0, pin_out}, {29'h0, e_out});
    chk({29'h0, pin_pullup}, {29'h0, e_pu});
    chk({29'h0, pin_in_en}, {29'h0, e_ie});
  end

  always @(posedge sys_clk) begin
    if (rnd_on) begin
      timer9_output <= 1'($urandom);
      system_clock_output <= 1'($urandom);
      alarm_n <= 1'($urandom);
      ext_drive <= 3'($urandom);
      ext_level <= 3'($urandom);
    end
  end

  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    fail_count++;
    close_out();
  end

  initial begin
    logic [7:0] a;
    int op;
    nrst = 1'b0;
    {reg_wr, reg_rd, rnd_on, timer9_output, system_clock_output, alarm_n} = 6'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    ext_drive = 3'h0;
    ext_level = 3'h0;
    void'($urandom(32'h4191));
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    foreach (addrs[i]) bus(1'b0, 1'b1, addrs[i], 32'h0);
    // back-to-back write and read of every place, unmapped ones included
    foreach (addrs[i]) begin
      bus(1'b1, 1'b0, addrs[i], 32'hffff_ffff);
      bus(1'b0, 1'b1, addrs[i], 32'h0);
    end
    // open-drain pin zero driving low, then released by data one
    bus(1'b1, 1'b0, PKFC_OFS_INEN, 32'h0);
    bus(1'b1, 1'b0, PKFC_OFS_DATA, 32'h2);
    bus(1'b0, 1'b1, PKFC_OFS_DATA, 32'h0);
    bus(1'b1, 1'b0, PKFC_OFS_DATA, 32'h5);
    bus(1'b0, 1'b1, PKFC_OFS_DATA, 32'h0);
    // pulled pins 2,1 and a board-held low pin 0 reach the data read through the synchroniser
    m_lvl = 3'h6;
    ext_drive <= 3'h1;
    bus(1'b1, 1'b0, PKFC_OFS_OUTCTL, 32'h0);
    bus(1'b1, 1'b0, PKFC_OFS_PULLUP, 32'h6);
    bus(1'b1, 1'b0, PKFC_OFS_INEN, 32'h7);
    repeat (5) bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b0, 1'b1, PKFC_OFS_DATA, 32'h0);
    rnd_on <= 1'b1;
    repeat (800) begin
      op = $urandom % 3;
      a = addrs[$urandom % addrs.size()];
      bus(op == 0, op == 1 && a != PKFC_OFS_DATA, a, $urandom);
    end
    // reset in mid-run with pull-ups and input paths on
    bus(1'b1, 1'b0, PKFC_OFS_PULLUP, 32'h6);
    bus(1'b1, 1'b0, PKFC_OFS_INEN, 32'h7);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    nrst <= 1'b0;
    #1;
    chk({29'h0, pin_pullup}, 32'h0);
    chk({29'h0, pin_in_en | ~pin_oe_n}, 32'h0);
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (addrs[i]) bus(1'b0, 1'b1, addrs[i], 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    close_out();
  end
endmodule // test_port_k_function_control
